// ---- rtl/bnh_pkg.sv ----
// Constants, states and timing for the bus node host serial port
package bnh_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_TIME_NS = 128000;
  localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int GAP_BITS = 10;
  localparam int DATA_BITS = 8;
  localparam int CNT_W = 16;

  // ****************************************************************
  // Pin synchroniser lanes and reset values
  // ****************************************************************
  localparam int PIN_MODE = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_BUS = 2;
  localparam int PIN_SDI = 3;
  localparam int PIN_CTRL = 4;
  localparam int PIN_N = 5;
  localparam logic [4:0] PIN_RST = 5'h1f;
  localparam logic IDLE_N_RST = 1'b0;

  // Frame sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP, ST_BLOCK} bnh_state_e;

endpackage

// ---- rtl/bnh_pair_buf.sv ----
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/100ps
module bnh_pair_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic [WIDTH-1:0] tail_r;
  logic tail_v_r;
  logic push;
  logic pop;

  // Ready only while the second slot is free, so a stall never overwrites
  assign in_ready_o = !tail_v_r;
  assign push = in_valid_i && !tail_v_r;
  assign pop = out_valid_o && out_ready_i;

  // Head slot drives the output straight from a flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= tail_v_r || push;
      out_data_o <= tail_v_r ? tail_r : in_data_i;
    end else if (push && !out_valid_o) begin
      out_valid_o <= 1'b1;
      out_data_o <= in_data_i;
    end
  end

  // Tail slot fills only behind a waiting head
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tail_v_r <= 1'b0;
      tail_r <= '0;
    end else if (pop) begin
      tail_v_r <= 1'b0;
    end else if (push && out_valid_o) begin
      tail_v_r <= 1'b1;
      tail_r <= in_data_i;
    end
  end

endmodule

// ---- rtl/bnh_host_port.sv ----
// Host serial port of the bus node: framing, shift clock, control handshake
`timescale 1ns/100ps
module bnh_host_port #(
  parameter int BIT_CYC = bnh_pkg::BIT_CYC,
  parameter int GAP_CYC = bnh_pkg::BIT_CYC * bnh_pkg::GAP_BITS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Mode straps from the host
  input wire logic mode_i,
  input wire logic cs_n_i,
  // Host data and shift clock
  input wire logic host_sdi_i,
  output logic host_sdo_o,
  output logic sck_o,
  // Open-drain control line
  input wire logic ctrl_i,
  output logic ctrl_o,
  output logic ctrl_oe_o,
  // Bus receiver and driver, high is recessive
  input wire logic bus_rx_i,
  output logic bus_tx_o,
  // Bus idle indication
  output logic idle_n_o,
  // Received bytes, user side
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  input wire logic rx_ready_i
);

  localparam logic [15:0] PH_Q = 16'(BIT_CYC / 4);
  localparam logic [15:0] PH_H = 16'(BIT_CYC / 2);
  localparam logic [15:0] PH_3Q = 16'((BIT_CYC * 3) / 4);
  localparam logic [15:0] PH_END = 16'(BIT_CYC - 1);
  localparam logic [15:0] GAP_END = 16'(GAP_CYC);
  localparam logic [2:0] IDX_LAST = 3'(bnh_pkg::DATA_BITS - 1);

  // Synchronous slave-host mode: mode high, chip select low
  function automatic logic is_sync(input logic m, input logic cs_n);
    is_sync = m && !cs_n;
  endfunction

  // UART-style mode: mode high, chip select high
  function automatic logic is_uart(input logic m, input logic cs_n);
    is_uart = m && cs_n;
  endfunction

  logic [bnh_pkg::PIN_N-1:0] meta_r;
  logic [bnh_pkg::PIN_N-1:0] pin_r;
  bnh_pkg::bnh_state_e state_r;
  logic [15:0] ph_r;
  logic [2:0] idx_r;
  logic [15:0] gap_r;
  logic [7:0] shift_r;
  logic tx_act_r;
  logic armed_r;
  logic push_r;
  logic buf_ready;
  logic sync_m;
  logic uart_m;
  logic bus_s;
  logic gap_done;
  logic host_req;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two flops per lane; only the second is ever read
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= bnh_pkg::PIN_RST;
      pin_r <= bnh_pkg::PIN_RST;
    end else begin
      meta_r <= {ctrl_i, host_sdi_i, bus_rx_i, cs_n_i, mode_i};
      pin_r <= meta_r;
    end
  end

  assign sync_m = is_sync(pin_r[bnh_pkg::PIN_MODE], pin_r[bnh_pkg::PIN_CS_N]);
  assign uart_m = is_uart(pin_r[bnh_pkg::PIN_MODE], pin_r[bnh_pkg::PIN_CS_N]);
  assign bus_s = pin_r[bnh_pkg::PIN_BUS];
  assign gap_done = (gap_r == GAP_END);
  // A full buffer stalls new transmit requests, so no reflected byte is lost
  assign host_req = sync_m && !pin_r[bnh_pkg::PIN_CTRL] && armed_r && !ctrl_oe_o
    && state_r == bnh_pkg::ST_IDLE && buf_ready;

  // ****************************************************************
  // End of message gap and idle output
  // ****************************************************************
  // Saturating count of quiet bus cycles; starts saturated so idle shows low
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_r <= GAP_END;
      idle_n_o <= bnh_pkg::IDLE_N_RST;
    end else begin
      if (!bus_s) begin
        gap_r <= '0;
      end else if (!gap_done) begin
        gap_r <= gap_r + 16'h0001;
      end
      idle_n_o <= !(bus_s && gap_done);
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  // Bit timing follows the received bus signal, own transmission included
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= bnh_pkg::ST_IDLE;
      ph_r <= '0;
      idx_r <= '0;
    end else begin
      ph_r <= (ph_r == PH_END) ? 16'h0000 : ph_r + 16'h0001;
      case (state_r)
        bnh_pkg::ST_IDLE: begin
          ph_r <= '0;
          if (!bus_s) begin
            state_r <= bnh_pkg::ST_START;
          end
        end
        bnh_pkg::ST_START: begin
          if (ph_r == PH_H && bus_s) begin
            state_r <= bnh_pkg::ST_IDLE;
          end else if (ph_r == PH_END) begin
            state_r <= bnh_pkg::ST_DATA;
            idx_r <= '0;
          end
        end
        bnh_pkg::ST_DATA: begin
          if (ph_r == PH_END) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r == IDX_LAST) begin
              state_r <= bnh_pkg::ST_STOP;
            end
          end
        end
        bnh_pkg::ST_STOP: begin
          if (ph_r == PH_H) begin
            state_r <= bus_s ? bnh_pkg::ST_IDLE : bnh_pkg::ST_BLOCK;
          end
        end
        bnh_pkg::ST_BLOCK: begin
          // Refuse everything until the gap, then restart the clock generator
          ph_r <= '0;
          if (gap_done && bus_s) begin
            state_r <= bnh_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= bnh_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Shift clock and data exchange with the host
  // ****************************************************************
  // Rise at bit start, fall at three quarters, only inside data bits
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_o <= 1'b0;
    end else if (sync_m && state_r == bnh_pkg::ST_DATA && ph_r == '0) begin
      sck_o <= 1'b1;
    end else if (ph_r == PH_3Q || state_r != bnh_pkg::ST_DATA) begin
      sck_o <= 1'b0;
    end
  end

  // Bus bit sampled mid-bit goes to the host; UART mode echoes the bus
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_sdo_o <= 1'b1;
      shift_r <= '0;
    end else if (uart_m) begin
      host_sdo_o <= bus_s;
    end else if (sync_m && state_r == bnh_pkg::ST_DATA && ph_r == PH_H) begin
      host_sdo_o <= bus_s;
      shift_r <= {bus_s, shift_r[7:1]};
    end
  end

  // Good frame enters the buffer at mid stop bit; full buffer drops it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      push_r <= 1'b0;
    end else begin
      push_r <= state_r == bnh_pkg::ST_STOP && ph_r == PH_H && bus_s && sync_m;
    end
  end

  // ****************************************************************
  // Bus driver
  // ****************************************************************
  // Host bit taken a quarter bit after the rising edge, once it has settled
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_tx_o <= 1'b1;
      tx_act_r <= 1'b0;
    end else if (uart_m) begin
      bus_tx_o <= pin_r[bnh_pkg::PIN_SDI];
      tx_act_r <= 1'b0;
    end else if (host_req) begin
      bus_tx_o <= 1'b0;
      tx_act_r <= 1'b1;
    end else if (tx_act_r && state_r == bnh_pkg::ST_DATA && ph_r == PH_Q) begin
      bus_tx_o <= pin_r[bnh_pkg::PIN_SDI];
    end else if (state_r == bnh_pkg::ST_STOP || state_r == bnh_pkg::ST_BLOCK) begin
      bus_tx_o <= 1'b1;
      tx_act_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Control line
  // ****************************************************************
  // Open drain: driven value is always low, enable holds the line down
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_o <= 1'b0;
      ctrl_oe_o <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      ctrl_o <= 1'b0;
      // One request per pull: re-armed only after the host lets go
      if (pin_r[bnh_pkg::PIN_CTRL] && !ctrl_oe_o) begin
        armed_r <= 1'b1;
      end else if (host_req) begin
        armed_r <= 1'b0;
      end
      if (host_req) begin
        ctrl_oe_o <= 1'b1;
      end else if (sync_m && state_r == bnh_pkg::ST_START && ph_r == PH_END) begin
        ctrl_oe_o <= 1'b1;
      end else if (state_r == bnh_pkg::ST_DATA && idx_r == IDX_LAST && ph_r == PH_H) begin
        ctrl_oe_o <= 1'b0;
      end else if (state_r == bnh_pkg::ST_BLOCK || !sync_m) begin
        ctrl_oe_o <= 1'b0;
      end
    end
  end

  bnh_pair_buf #(
    .WIDTH(8)
  ) u_buf (
    .clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(push_r),
    .in_data_i(shift_r),
    .in_ready_o(buf_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_byte_o),
    .out_ready_i(rx_ready_i)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_last_mid;
    state_r == bnh_pkg::ST_DATA && idx_r == IDX_LAST && ph_r == PH_H;
  endsequence

  ctrl_release_a: assert property (s_last_mid |=> !ctrl_oe_o)
    else $error("control not released mid last bit");
  ctrl_grab_a: assert property (sync_m && state_r == bnh_pkg::ST_START && ph_r == PH_END
    |=> ctrl_oe_o && state_r == bnh_pkg::ST_DATA)
    else $error("control not pulled at first data bit");
  frame_block_a: assert property (state_r == bnh_pkg::ST_STOP && ph_r == PH_H && !bus_s
    |=> state_r == bnh_pkg::ST_BLOCK)
    else $error("framing error not caught");
  block_no_sck_a: assert property (state_r == bnh_pkg::ST_BLOCK ##1
    state_r == bnh_pkg::ST_BLOCK |-> !sck_o)
    else $error("shift clock during blocked state");
  block_exit_a: assert property (state_r == bnh_pkg::ST_BLOCK && !(gap_done && bus_s)
    |=> state_r == bnh_pkg::ST_BLOCK)
    else $error("left blocked state before gap");
  idle_busy_a: assert property (!bus_s |=> ##1 idle_n_o)
    else $error("idle shown during bus activity");
  sck_in_data_a: assert property ($rose(sck_o) |-> $past(state_r) == bnh_pkg::ST_DATA
    && $past(ph_r) == '0)
    else $error("shift clock outside data bit");
  echo_a: assert property (uart_m |=> host_sdo_o == $past(bus_s))
    else $error("bus not echoed in uart mode");
  tx_bit_a: assert property (tx_act_r && !uart_m && state_r == bnh_pkg::ST_DATA
    && ph_r == PH_Q |=> bus_tx_o == $past(pin_r[bnh_pkg::PIN_SDI]))
    else $error("host bit not driven to bus");
  reflect_a: assert property (sync_m && state_r == bnh_pkg::ST_DATA && ph_r == PH_H
    |=> host_sdo_o == $past(bus_s) ##1 sck_o [*2])
    else $error("read-back bit not passed to host");

endmodule

// ---- sim/bnh_host_model.sv ----
// Behavioural host serial port, shift-clock slave of the bus node
`timescale 1ns/100ps
module bnh_host_model (
  // Request timing clock
  input wire logic clk_i,
  // Shift clock and data from the device
  input wire logic sck_i,
  input wire logic sdo_i,
  // Data to the device
  output logic sdi_o,
  // High pulls the control line low
  output logic pull_o,
  // Last byte taken in, bus order, and byte count
  output logic [7:0] got_o,
  output int n_got_o
);
  logic [7:0] tx_sr = 8'h00;
  logic [7:0] rx_sr = 8'h00;
  int nbit = 0;

  // Host port shifts MSB first, the bus LSB first
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // Quiet lines at time zero
  initial begin
    sdi_o = 1'b1;
    pull_o = 1'b0;
    got_o = 8'h00;
    n_got_o = 0;
  end

  // Load the shift register, reversed to bus order
  task automatic load(input logic [7:0] b);
    tx_sr = rev8(b);
  endtask

  // One request per byte; the pull outlasts 1 us
  task automatic request(input logic [7:0] b);
    load(b);
    @(posedge clk_i);
    #1 pull_o = 1'b1;
    repeat (24) @(posedge clk_i);
    #1 pull_o = 1'b0;
  endtask

  // Drop a half-shifted byte after a framing error
  task automatic resync();
    nbit = 0;
  endtask

  // Idle-low clock: new bit on the leading edge; refill inverted so nothing stays stale
  always @(posedge sck_i) begin
    sdi_o <= tx_sr[7];
    tx_sr <= {tx_sr[6:0], ~tx_sr[7]};
  end

  // Sample on the trailing edge; eight bits make a byte
  always @(negedge sck_i) begin
    rx_sr = {rx_sr[6:0], sdo_i};
    nbit++;
    if (nbit == 8) begin
      got_o = rev8(rx_sr);
      n_got_o++;
      nbit = 0;
      sdi_o <= 1'b1; // Data line idles high between bytes
    end
  end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the bus node host serial port
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  localparam int BITC = 16;
  localparam int GAPC = 160;
  logic core_clk_i, arst_n_i, mode_i, cs_n_i, rx_ready_i, tb_bus, stall, uart;
  logic host_sdo_o, sck_o, ctrl_oe_o, bus_tx_o, idle_n_o, rx_valid_o;
  logic [7:0] rx_byte_o, got, b, e, x;
  logic host_sdi, pull, ctrl_w, bus_w, ctrl_d;
  logic [31:0] seed = 32'h36;
  logic [31:0] r;
  logic [7:0] exp_q[$];
  int n_got, n_mismatch, n_tests, n_sck, k;

  // Open-drain control and wired-AND bus, both resting high
  assign ctrl_w = (ctrl_oe_o ? ctrl_d : 1'b1) & ~pull;
  assign bus_w = bus_tx_o & tb_bus;

  bnh_host_port #(.BIT_CYC(BITC), .GAP_CYC(GAPC)) bnh_host_port_i (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .mode_i(mode_i), .cs_n_i(cs_n_i),
    .host_sdi_i(host_sdi), .host_sdo_o(host_sdo_o), .sck_o(sck_o),
    .ctrl_i(ctrl_w), .ctrl_o(ctrl_d), .ctrl_oe_o(ctrl_oe_o),
    .bus_rx_i(bus_w), .bus_tx_o(bus_tx_o), .idle_n_o(idle_n_o),
    .rx_valid_o(rx_valid_o), .rx_byte_o(rx_byte_o), .rx_ready_i(rx_ready_i));

  bnh_host_model bnh_host_model_i (
    .clk_i(core_clk_i), .sck_i(sck_o), .sdo_i(host_sdo_o), .sdi_o(host_sdi),
    .pull_o(pull), .got_o(got), .n_got_o(n_got));

  // 20 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  function automatic logic [7:0] rb();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Random receiver stalls, forced off while a full buffer is wanted
  always @(posedge core_clk_i) begin
    r = {24'h0, rb()};
    #1 rx_ready_i = ~stall & r[0];
  end

  // Count shift clock pulses
  always @(posedge sck_o) n_sck++;

  // Scoreboard: oldest note against each accepted byte
  always @(posedge core_clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      `CHK("byte pending", 1'b1, exp_q.size() > 0)
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        `CHK("rx byte", e, rx_byte_o)
      end
    end
  end

  // ****************************************************************
  // Bus side frames and waits
  // ****************************************************************
  task automatic bus_frame(input logic [7:0] v, input logic stop);
    logic [9:0] f;
    f = {stop, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_i);
      #1 tb_bus = f[i];
      repeat (BITC / 2) @(posedge core_clk_i);
      #5;
      if (uart) `CHK("echo", f[i], host_sdo_o)
      repeat (BITC / 2 - 1) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    #1 tb_bus = 1'b1;
  endtask

  task automatic rx_one(input logic [7:0] v, input logic stop, input int ns, input logic keep);
    if (keep) exp_q.push_back(v);
    n_sck = 0;
    bus_frame(v, stop);
    #5;
    `CHK("sck pulses", ns, n_sck)
    if (ns == 8) `CHK("host byte", v, got)
  endtask

  task automatic quiet_gap();
    repeat (GAPC + 2 * BITC) @(posedge core_clk_i);
    #5;
    `CHK("idle flag", 1'b0, idle_n_o)
  endtask

  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog at 30000 cycles, far above a run of about 3300 cycles
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {arst_n_i, stall, uart, rx_ready_i} = 4'h0;
    {mode_i, cs_n_i, tb_bus} = 3'b101;
    repeat (6) @(posedge core_clk_i);
    #1;
    `CHK("idle in reset", 1'b0, idle_n_o)
    `CHK("ctrl in reset", 1'b1, ctrl_w)
    `CHK("ctrl drive", 1'b0, ctrl_d)
    arst_n_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    $display("test reset done");
    // Unrequested bytes, boundary values first, host data swapped in
    for (int i = 0; i < 4; i++) begin
      b = i == 0 ? 8'h00 : i == 1 ? 8'hff : rb();
      bnh_host_model_i.load(rb());
      rx_one(b, 1'b1, 8, 1'b1);
      `CHK("idle flag busy", 1'b1, idle_n_o)
    end
    quiet_gap();
    $display("test receive done");
    // Host requests, one byte each; the last meets a dominant data bit 3
    for (int i = 0; i < 3; i++) begin
      b = rb();
      k = n_got;
      x = i == 2 ? b & 8'hf7 : b;
      exp_q.push_back(x);
      fork
        bnh_host_model_i.request(b);
        if (i == 2) begin
          repeat (71) @(posedge core_clk_i);
          #1 tb_bus = 1'b0;
          repeat (12) @(posedge core_clk_i);
          #1 tb_bus = 1'b1;
        end
      join
      for (int t = 0; t < 400 && n_got == k; t++) @(posedge core_clk_i);
      `CHK("read-back", x, got)
      repeat (2 * BITC) @(posedge core_clk_i);
    end
    quiet_gap();
    $display("test transmit done");
    // Bad stop bit, then a frame refused until the gap
    rx_one(rb(), 1'b0, 8, 1'b0);
    bnh_host_model_i.resync();
    rx_one(rb(), 1'b1, 0, 1'b0);
    quiet_gap();
    rx_one(rb(), 1'b1, 8, 1'b1);
    $display("test framing done");
    // Receiver stalls: two held, third dropped; start from an empty buffer
    for (int t = 0; t < 64 && exp_q.size() > 0; t++) @(posedge core_clk_i);
    #1 stall = 1'b1;
    rx_one(rb(), 1'b1, 8, 1'b1);
    rx_one(rb(), 1'b1, 8, 1'b1);
    rx_one(rb(), 1'b1, 8, 1'b0);
    `CHK("valid held", 1'b1, rx_valid_o)
    stall = 1'b0;
    repeat (40) @(posedge core_clk_i);
    $display("test stall done");
    // Buffered selection stays quiet; UART mode echoes
    #1 {mode_i, cs_n_i} = 2'b00;
    rx_one(rb(), 1'b1, 0, 1'b0);
    {mode_i, cs_n_i, uart} = 3'b111;
    rx_one(rb(), 1'b1, 0, 1'b0);
    rx_one(rb(), 1'b0, 0, 1'b0);
    uart = 1'b0;
    $display("test modes done");
    `CHK("buffer drained", 0, exp_q.size())
    tally_and_finish();
  end
endmodule
